// ### hw/nsx_pkg.sv
/*
 Package for the nibble-exchange / xor / direction-load execute block.
 Assumes a 12-bit instruction word and 8-bit data path.
*/
// Contract
// - Nibble exchange swaps addressed register's nibbles.
// - Exchange with dest 0 writes working register.
// - Exchange with dest 1 writes file, flags kept.
// - Direction load copies W, field 6, flags kept.
// - Literal xor updates W and zero flag.
// - Register xor uses file register, updates zero.
// - Register xor with dest 0 writes W.
// - Register xor with dest 1 writes file.
package nsx_pkg;
  localparam int unsigned NSX_IW = 12;
  localparam int unsigned NSX_DW = 8;
  localparam int unsigned NSX_AW = 5;
  localparam logic [5:0] NSX_OPC_EXCH = 6'h0E;
  localparam logic [5:0] NSX_OPC_RXOR = 6'h06;
  localparam logic [3:0] NSX_OPC_LXOR = 4'hF;
  localparam logic [8:0] NSX_OPC_DIRL = 9'h000;
  localparam logic [2:0] NSX_DIR_PORT = 3'h6;
  localparam logic [7:0] NSX_W_RST = 8'h00;
  localparam logic [7:0] NSX_DIR_RST = 8'hFF;
  localparam int unsigned NSX_D_BIT = 5;
  typedef enum logic [2:0] {
    NSX_NOP = 3'b000,
    NSX_EXCH = 3'b001,
    NSX_DIRL = 3'b010,
    NSX_LXOR = 3'b011,
    NSX_RXOR = 3'b100
  } nsx_op_e;
endpackage : nsx_pkg

// ### hw/nsx_decode.sv
/*
 Combinational opcode decoder.
 Assumes instruction word is stable during the cycle.
*/
`timescale 1ns/1ps
`default_nettype none
module nsx_decode
  import nsx_pkg::*;
(
  // Instruction
  input wire logic [11:0] instr,
  // Decoded
  output nsx_pkg::nsx_op_e op,
  output logic dest_file,
  output logic [4:0] faddr
);
  always_comb begin
    op = NSX_NOP;
    if (instr[11:6] == NSX_OPC_EXCH) begin
      op = NSX_EXCH;
    end else if (instr[11:6] == NSX_OPC_RXOR) begin
      op = NSX_RXOR;
    end else if (instr[11:8] == NSX_OPC_LXOR) begin
      op = NSX_LXOR;
    end else if (instr[11:3] == NSX_OPC_DIRL && instr[2:0] == NSX_DIR_PORT) begin
      op = NSX_DIRL;
    end
  end
  assign dest_file = instr[NSX_D_BIT];
  assign faddr = instr[4:0];
endmodule : nsx_decode
`default_nettype wire

// ### hw/nsx_exec.sv
/*
 Execute unit for nibble exchange, xor forms and port direction load.
 Assumes the register file is outside: it gives read data combinationally
 for file_addr and takes the write strobe at the clock edge.
 Assumes the outside file forwards a pending write to a read of the
 same address in the following cycle; this block does no forwarding.
 The read address stays combinational so that the read needs no extra
 cycle; every other output comes from the state register.
*/
`timescale 1ns/1ps
`default_nettype none
module nsx_exec
  import nsx_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Instruction issue, one per cycle
  input wire logic instr_valid,
  input wire logic [11:0] instr,
  // File register access
  output logic [4:0] file_addr,
  input wire logic [7:0] file_rdata,
  output logic file_we,
  output logic [4:0] file_waddr,
  output logic [7:0] file_wdata,
  // Core state
  output logic [7:0] w_reg,
  output logic zero_flag,
  output logic [7:0] port_dir
);
  typedef struct packed {
    logic [7:0] w;
    logic z;
    logic [7:0] dir;
    logic we;
    logic [4:0] waddr;
    logic [7:0] wdata;
  } nsx_state_s;

  nsx_state_s st_q;
  nsx_state_s st_d;
  nsx_op_e op;
  logic dest_file;
  logic [4:0] faddr;
  logic [7:0] res;

  nsx_decode u_dec (
    .instr(instr),
    .op(op),
    .dest_file(dest_file),
    .faddr(faddr)
  );

  assign file_addr = faddr;

  // Next state: hold everything, strobe is a one-cycle pulse
  always_comb begin
    st_d = st_q;
    // Write strobe drops unless this cycle writes the file
    st_d.we = 1'b0;
    res = 8'h00;
    if (instr_valid) begin
      unique case (op)
        NSX_EXCH: begin
          res = {file_rdata[3:0], file_rdata[7:4]};
          if (dest_file) begin
            st_d.we = 1'b1;
            st_d.waddr = faddr;
            st_d.wdata = res;
          end else begin
            st_d.w = res;
          end
        end
        NSX_DIRL: begin
          st_d.dir = st_q.w;
        end
        NSX_LXOR: begin
          res = st_q.w ^ instr[7:0];
          st_d.w = res;
          st_d.z = (res == 8'h00);
        end
        NSX_RXOR: begin
          res = st_q.w ^ file_rdata;
          st_d.z = (res == 8'h00);
          if (dest_file) begin
            st_d.we = 1'b1;
            st_d.waddr = faddr;
            st_d.wdata = res;
          end else begin
            st_d.w = res;
          end
        end
        NSX_NOP: begin
        end
      endcase
    end
  end

  // One edge commits each instruction
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st_q <= '{w: NSX_W_RST, z: 1'b0, dir: NSX_DIR_RST, we: 1'b0,
                waddr: 5'h00, wdata: 8'h00};
    end else begin
      st_q <= st_d;
    end
  end

  assign w_reg = st_q.w;
  assign zero_flag = st_q.z;
  assign port_dir = st_q.dir;
  assign file_we = st_q.we;
  assign file_waddr = st_q.waddr;
  assign file_wdata = st_q.wdata;

  a_exch_swap: assert property (@(posedge sys_clk) disable iff (rst)
    instr_valid && op == NSX_EXCH && !dest_file |=>
      w_reg == {$past(file_rdata[3:0]), $past(file_rdata[7:4])} && !file_we)
    else $error("exchange to W wrong");
  a_exch_file: assert property (@(posedge sys_clk) disable iff (rst)
    instr_valid && op == NSX_EXCH && dest_file |=>
      file_we && file_wdata == {$past(file_rdata[3:0]), $past(file_rdata[7:4])}
      && file_waddr == $past(faddr) && $stable(zero_flag) && $stable(w_reg))
    else $error("exchange to file wrong");
  a_dir_load: assert property (@(posedge sys_clk) disable iff (rst)
    instr_valid && op == NSX_DIRL |=> port_dir == $past(w_reg) && $stable(zero_flag))
    else $error("direction load wrong");
  a_lxor_res: assert property (@(posedge sys_clk) disable iff (rst)
    instr_valid && op == NSX_LXOR |=>
      w_reg == ($past(w_reg) ^ $past(instr[7:0])) && zero_flag == (w_reg == 8'h00))
    else $error("literal xor wrong");
  a_rxor_zero: assert property (@(posedge sys_clk) disable iff (rst)
    instr_valid && op == NSX_RXOR |=>
      zero_flag == (($past(w_reg) ^ $past(file_rdata)) == 8'h00))
    else $error("register xor zero wrong");
  a_rxor_w: assert property (@(posedge sys_clk) disable iff (rst)
    instr_valid && op == NSX_RXOR && !dest_file |=>
      w_reg == ($past(w_reg) ^ $past(file_rdata)) && !file_we)
    else $error("register xor to W wrong");
  a_rxor_file: assert property (@(posedge sys_clk) disable iff (rst)
    instr_valid && op == NSX_RXOR && dest_file |=>
      file_we && file_wdata == ($past(w_reg) ^ $past(file_rdata)) && $stable(w_reg))
    else $error("register xor to file wrong");
  a_exch_decode: assert property (@(posedge sys_clk) disable iff (rst)
    instr_valid && instr[11:6] == 6'h0E |-> op == NSX_EXCH)
    else $error("exchange decode wrong");
  a_one_cycle: assert property (@(posedge sys_clk) disable iff (rst)
    file_we |=> !file_we || $past(instr_valid))
    else $error("stray write strobe");

  // Decode of the remaining opcodes
  a_rxor_decode: assert property (@(posedge sys_clk) disable iff (rst)
    instr_valid && instr[11:6] == 6'h06 |-> op == NSX_RXOR)
    else $error("register xor decode wrong");
  a_lxor_decode: assert property (@(posedge sys_clk) disable iff (rst)
    instr_valid && instr[11:8] == 4'hF |-> op == NSX_LXOR)
    else $error("literal xor decode wrong");
  a_dirl_decode: assert property (@(posedge sys_clk) disable iff (rst)
    instr_valid && instr == 12'h006 |-> op == NSX_DIRL)
    else $error("direction load decode wrong");

  // Flags and registers that an instruction must leave alone
  a_exch_zero: assert property (@(posedge sys_clk) disable iff (rst)
    instr_valid && op == NSX_EXCH |=>
      $stable(zero_flag) && $stable(port_dir))
    else $error("exchange touched flag");
  a_dir_keep: assert property (@(posedge sys_clk) disable iff (rst)
    instr_valid && op == NSX_DIRL |=>
      $stable(w_reg) && !file_we)
    else $error("direction load touched W");
  a_dir_refuse: assert property (@(posedge sys_clk) disable iff (rst)
    instr_valid && instr[11:3] == NSX_OPC_DIRL && instr[2:0] != NSX_DIR_PORT |=>
      $stable(port_dir) && $stable(w_reg) && $stable(zero_flag))
    else $error("bad direction field acted");
  a_lxor_keep: assert property (@(posedge sys_clk) disable iff (rst)
    instr_valid && op == NSX_LXOR |=>
      !file_we && $stable(port_dir))
    else $error("literal xor wrote file");
  a_rxor_addr: assert property (@(posedge sys_clk) disable iff (rst)
    instr_valid && op == NSX_RXOR && dest_file |=>
      file_waddr == $past(faddr) && $stable(port_dir))
    else $error("register xor address wrong");

  // Only an instruction may change state
  a_idle_hold: assert property (@(posedge sys_clk) disable iff (rst)
    !instr_valid |=>
      $stable(w_reg) && $stable(zero_flag) && $stable(port_dir) && !file_we)
    else $error("state moved while idle");
  a_dir_only: assert property (@(posedge sys_clk) disable iff (rst)
    !$stable(port_dir) |->
      $past(instr_valid) && $past(op) == NSX_DIRL)
    else $error("direction changed without load");
  a_zero_only: assert property (@(posedge sys_clk) disable iff (rst)
    !$stable(zero_flag) |->
      $past(instr_valid) && ($past(op) == NSX_LXOR || $past(op) == NSX_RXOR))
    else $error("zero flag changed by wrong op");
  a_w_only: assert property (@(posedge sys_clk) disable iff (rst)
    !$stable(w_reg) |->
      $past(instr_valid) && !$past(dest_file) || $past(op) == NSX_LXOR)
    else $error("W changed without result");

  // Reset values reach the outputs one edge later
  a_reset_state: assert property (@(posedge sys_clk)
    rst |=>
      w_reg == NSX_W_RST && port_dir == NSX_DIR_RST && !zero_flag && !file_we)
    else $error("reset state wrong");
endmodule : nsx_exec
`default_nettype wire

// ### verif/nsx_exec_tb.sv
/*
 Self-checking bench for nsx_exec: drives instructions and file read data.
 Assumes results show 1 ns after the taking edge.
*/
`timescale 1ns/1ps
`default_nettype none
module nsx_exec_tb;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic instr_valid = 1'b0;
  logic [11:0] instr = 12'h000;
  logic [7:0] file_rdata = 8'h00;
  logic [4:0] file_addr;
  logic [4:0] file_waddr;
  logic file_we;
  logic zero_flag;
  logic [7:0] file_wdata;
  logic [7:0] w_reg;
  logic [7:0] port_dir;
  int error_cnt = 0;
  int n_compared = 0;
  int cyc = 0;
  nsx_exec uut (.sys_clk(sys_clk), .rst(rst), .instr_valid(instr_valid), .instr(instr),
    .file_addr(file_addr), .file_rdata(file_rdata), .file_we(file_we),
    .file_waddr(file_waddr), .file_wdata(file_wdata), .w_reg(w_reg),
    .zero_flag(zero_flag), .port_dir(port_dir));
  initial begin
    forever #4 sys_clk = ~sys_clk;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic issue(input logic [11:0] op, input logic [7:0] rd);
    instr = op;
    file_rdata = rd;
    instr_valid = 1'b1;
    @(posedge sys_clk);
    #1;
  endtask : issue
  task automatic idle;
    instr_valid = 1'b0;
    @(posedge sys_clk);
    #1;
  endtask : idle
  task automatic t_exch;
    issue(12'h3A3, 8'hA5);
    chk({3'h0, file_addr}, 8'h03);
    chk({7'h00, file_we}, 8'h01);
    chk({3'h0, file_waddr}, 8'h03);
    chk(file_wdata, 8'h5A);
    chk(w_reg, 8'h00);
    issue(12'h381, 8'hA5);
    chk(w_reg, 8'h5A);
    chk({7'h00, file_we}, 8'h00);
    idle();
    chk(w_reg, 8'h5A);
    $display("exchange test done");
  endtask : t_exch
  task automatic t_lxor;
    issue(12'hFEF, 8'h00);
    chk(w_reg, 8'hB5);
    issue(12'hFAF, 8'h00);
    chk(w_reg, 8'h1A);
    chk({7'h00, zero_flag}, 8'h00);
    issue(12'hF1A, 8'h00);
    chk({7'h00, zero_flag}, 8'h01);
    issue(12'h3A3, 8'hA5);
    chk({7'h00, zero_flag}, 8'h01);
    idle();
    $display("literal xor test done");
  endtask : t_lxor
  task automatic t_dir;
    issue(12'h006, 8'h00);
    chk(port_dir, 8'h00);
    chk({7'h00, zero_flag}, 8'h01);
    issue(12'hFA5, 8'h00);
    issue(12'h005, 8'h00);
    chk(port_dir, 8'h00);
    chk({7'h00, zero_flag}, 8'h00);
    issue(12'h006, 8'h00);
    chk(port_dir, 8'hA5);
    idle();
    $display("direction load test done");
  endtask : t_dir
  task automatic t_rxor;
    issue(12'h1A2, 8'hA5);
    chk({7'h00, file_we}, 8'h01);
    chk({3'h0, file_waddr}, 8'h02);
    chk(file_wdata, 8'h00);
    chk({7'h00, zero_flag}, 8'h01);
    chk(w_reg, 8'hA5);
    issue(12'h182, 8'h0F);
    chk(w_reg, 8'hAA);
    chk({7'h00, zero_flag}, 8'h00);
    idle();
    $display("register xor test done");
  endtask : t_rxor
  task automatic end_sim;
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : end_sim
  // Hang guard
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 500) begin
      error_cnt++;
      end_sim();
    end
  end
  initial begin
    repeat (12) @(posedge sys_clk);
    #1;
    rst = 1'b0;
    chk(port_dir, 8'hFF);
    chk(w_reg, 8'h00);
    t_exch();
    t_lxor();
    t_dir();
    t_rxor();
    end_sim();
  end
endmodule : nsx_exec_tb
`default_nettype wire
